//--- shared/imucfg_defines.svh
`ifndef IMUCFG_DEFINES_SVH
`define IMUCFG_DEFINES_SVH

// wishbone byte offsets
`define IMUCFG_OFS_CMD 8'h00
`define IMUCFG_OFS_PAR0 8'h04
`define IMUCFG_OFS_STATUS 8'h20
`define IMUCFG_OFS_CRC 8'h24
`define IMUCFG_OFS_DEC 8'h28
`define IMUCFG_OFS_CONF 8'h2c
`define IMUCFG_OFS_SERIAL 8'h30
`define IMUCFG_OFS_RATE 8'h34
`define IMUCFG_OFS_GAP 8'h38
`define IMUCFG_OFS_SPACING 8'h3c
`define IMUCFG_OFS_RESP0 8'h40
`define IMUCFG_OFS_BIAS0 8'h80

// command codes
`define IMUCFG_CMD_GYRO_UNIT 8'h01
`define IMUCFG_CMD_SAMPLE_RATE 8'h02
`define IMUCFG_CMD_SAMPLE_EXT 8'h03
`define IMUCFG_CMD_PPS_FILTER 8'h04
`define IMUCFG_CMD_PPS_UNIT 8'h05
`define IMUCFG_CMD_SERIAL 8'h06
`define IMUCFG_CMD_READ_BIAS 8'h07
`define IMUCFG_CMD_SAVE 8'h08

// execution status
`define IMUCFG_ST_OK 8'h00
`define IMUCFG_ST_BAD_PARAM 8'h01
`define IMUCFG_ST_BAD_CMD 8'h02

// response terminator byte
`define IMUCFG_CR 8'h0d
`define IMUCFG_CRC_POLY 8'h07
`define IMUCFG_CRC_INIT 8'h00

// reset values
`define IMUCFG_RST_GYRO_UNIT 4'h0
`define IMUCFG_RST_RATE 12'h7d0
`define IMUCFG_RST_PPS_FILT 3'h4
`define IMUCFG_RST_PPS_HZ 9'h106
`define IMUCFG_RST_PPS_UNIT 2'h0
`define IMUCFG_RST_BIT_RATE 24'h0e1000
`define IMUCFG_RST_PARITY 2'h0

// decimals of the bias read-out words: gyro, accel, reserved
`define IMUCFG_DEC_GYRO 4'h5
`define IMUCFG_DEC_ACC 4'h6
`define IMUCFG_DEC_RSV 4'h7

// timing
`define IMUCFG_CLK_MHZ 200
`define IMUCFG_TICK_US 1
`define IMUCFG_TICK_CYC (`IMUCFG_CLK_MHZ * `IMUCFG_TICK_US)
`define IMUCFG_MAX_DELAY_US 20'hf4240

`endif

//--- shared/imucfg_pkg.sv
package imucfg_pkg;

  typedef enum logic [1:0] {
    IMUCFG_IDLE = 2'b01,
    IMUCFG_CRC = 2'b10
  } imucfg_seq_type;

  typedef struct packed {
    imucfg_seq_type seq;
    logic [7:0] cmd;
    logic [7:0] status;
    logic [3:0] nparam;
    logic [5:0] idx;
    logic [7:0] crc;
    logic [5:0][31:0] par;
    logic [8:0][31:0] resp;
    logic [8:0][31:0] bias;
    logic [3:0] gyro_unit;
    logic [11:0] rate;
    logic ext_trig;
    logic multi;
    logic [19:0] gap;
    logic [19:0] spacing;
    logic startup;
    logic [2:0] pps_filt;
    logic [8:0] pps_hz;
    logic [1:0] pps_unit;
    logic [23:0] bit_rate;
    logic stop2;
    logic [1:0] parity;
    logic term;
    logic crlf;
    logic idle_off;
    logic pend;
    logic [23:0] p_bit_rate;
    logic p_stop2;
    logic [1:0] p_parity;
    logic p_term;
    logic p_crlf;
    logic p_idle_off;
    logic save;
    logic [7:0] tick_cnt;
    logic [19:0] since_start;
    logic [19:0] since_end;
    logic grant;
    logic drv_en;
    logic ack;
    logic [31:0] dat;
  } imucfg_state_type;

endpackage

//--- hw/imucfg_crc8_step.sv
`timescale 1ns/100ps
// one byte through a msb-first crc-8 register
module imucfg_crc8_step #(
  parameter logic [7:0] POLY = 8'h07
) (
  input wire logic [7:0] crc_in,
  input wire logic [7:0] byte_in,
  output logic [7:0] crc_out
);
  always_comb
  begin
    logic [7:0] c;
    c = crc_in ^ byte_in;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ({c[6:0], 1'b0} ^ POLY) : {c[6:0], 1'b0};
    end
    crc_out = c;
  end
endmodule // imucfg_crc8_step

//--- hw/imucfg_cmd.sv
`timescale 1ns/100ps
`include "imucfg_defines.svh"
module imucfg_cmd (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic frame_req_in,
  input wire logic frame_end_in,
  input wire logic tx_active_in,
  output logic frame_grant_out,
  output logic driver_enable_out,
  output logic [3:0] gyro_unit_out,
  output logic [11:0] sample_rate_out,
  output logic ext_trigger_out,
  output logic multi_module_out,
  output logic startup_frames_enable_out,
  output logic [2:0] pps_filter_out,
  output logic [8:0] pps_cutoff_hz_out,
  output logic [1:0] pps_unit_out,
  output logic [23:0] bit_rate_out,
  output logic two_stop_bits_out,
  output logic [1:0] parity_out,
  output logic receive_termination_on_out,
  output logic frame_crlf_enable_out,
  output logic driver_idle_off_out,
  output logic save_request_out
);
  imucfg_pkg::imucfg_state_type s_q, s_d;
  logic rst_meta_q, rst_sync_q;
  logic [7:0] crc_byte, crc_next;

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  imucfg_crc8_step #(
    .POLY(`IMUCFG_CRC_POLY)
  ) u_crc (
    .crc_in(s_q.crc),
    .byte_in(crc_byte),
    .crc_out(crc_next)
  );

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        old[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return old;
  endfunction

  // response bytes: command, status, then each echoed word msb first
  always_comb
  begin
    logic [5:0] off;
    logic [3:0] w;
    off = s_q.idx - 6'h02;
    w = off[5:2];
    if (s_q.idx == 6'h00)
    begin
      crc_byte = s_q.cmd;
    end
    else if (s_q.idx == 6'h01)
    begin
      crc_byte = s_q.status;
    end
    else
    begin
      crc_byte = s_q.resp[w][8*(3 - off[1:0]) +: 8];
    end
  end

  always_comb
  begin
    logic acc;
    logic wr;
    logic ok;
    logic [31:0] p0, p1, p2, p3, p4, p5;
    logic [7:0] a;
    logic [5:0] last;
    s_d = s_q;
    a = wb_adr_in;
    acc = wb_cyc_in && wb_stb_in && !s_q.ack;
    wr = acc && wb_we_in;
    p0 = s_q.par[0];
    p1 = s_q.par[1];
    p2 = s_q.par[2];
    p3 = s_q.par[3];
    p4 = s_q.par[4];
    p5 = s_q.par[5];
    ok = 1'b0;
    s_d.save = 1'b0;
    s_d.grant = 1'b0;
    s_d.ack = acc;
    s_d.dat = 32'h0;
    last = {s_q.nparam, 2'b00} + 6'h01;

    // bus reads; unmapped addresses answer zero
    if (acc && !wb_we_in)
    begin
      case (a)
        `IMUCFG_OFS_CMD: s_d.dat = {30'h0, s_q.pend, s_q.seq[1]};
        `IMUCFG_OFS_STATUS:
          s_d.dat = {12'h0, s_q.nparam, s_q.cmd, s_q.status};
        `IMUCFG_OFS_CRC: s_d.dat = {16'h0, `IMUCFG_CR, s_q.crc};
        `IMUCFG_OFS_DEC:
          s_d.dat = {20'h0, `IMUCFG_DEC_RSV, `IMUCFG_DEC_ACC,
                     `IMUCFG_DEC_GYRO};
        `IMUCFG_OFS_CONF:
          s_d.dat = {11'h0, s_q.pps_hz, s_q.pps_unit, s_q.pps_filt,
                     s_q.startup, s_q.multi, s_q.ext_trig, s_q.gyro_unit};
        `IMUCFG_OFS_SERIAL:
          s_d.dat = {s_q.idle_off, s_q.crlf, s_q.term, s_q.parity,
                     s_q.stop2, 2'b00, s_q.bit_rate};
        `IMUCFG_OFS_RATE: s_d.dat = {20'h0, s_q.rate};
        `IMUCFG_OFS_GAP: s_d.dat = {12'h0, s_q.gap};
        `IMUCFG_OFS_SPACING: s_d.dat = {12'h0, s_q.spacing};
        default:
        begin
          if (a >= `IMUCFG_OFS_PAR0 && a < 8'h1c && a[1:0] == 2'b00)
          begin
            s_d.dat = s_q.par[3'(a[4:2] - 3'h1)];
          end
          else if (a >= `IMUCFG_OFS_RESP0 && a < 8'h64 && a[1:0] == 2'b00)
          begin
            s_d.dat = s_q.resp[4'(a[5:2])];
          end
          else if (a >= `IMUCFG_OFS_BIAS0 && a < 8'ha4 && a[1:0] == 2'b00)
          begin
            s_d.dat = s_q.bias[4'(a[5:2])];
          end
        end
      endcase
    end

    // reading the crc ends the response; serial changes wait for it
    if (acc && !wb_we_in && a == `IMUCFG_OFS_CRC && s_q.pend &&
        s_q.seq == imucfg_pkg::IMUCFG_IDLE)
    begin
      s_d.pend = 1'b0;
      s_d.bit_rate = s_q.p_bit_rate;
      s_d.stop2 = s_q.p_stop2;
      s_d.parity = s_q.p_parity;
      s_d.term = s_q.p_term;
      s_d.crlf = s_q.p_crlf;
      s_d.idle_off = s_q.p_idle_off;
    end

    if (wr && a >= `IMUCFG_OFS_PAR0 && a < 8'h1c && a[1:0] == 2'b00)
    begin
      s_d.par[3'(a[4:2] - 3'h1)] =
        merge(s_q.par[3'(a[4:2] - 3'h1)], wb_dat_in, wb_sel_in);
    end
    if (wr && a >= `IMUCFG_OFS_BIAS0 && a < 8'ha4 && a[1:0] == 2'b00)
    begin
      s_d.bias[4'(a[5:2])] = merge(s_q.bias[4'(a[5:2])], wb_dat_in,
                                   wb_sel_in);
    end

    case (s_q.seq)
      imucfg_pkg::IMUCFG_IDLE:
      begin
        // a command written while the crc runs is dropped
        if (wr && a == `IMUCFG_OFS_CMD && wb_sel_in[0])
        begin
          s_d.cmd = wb_dat_in[7:0];
          s_d.status = `IMUCFG_ST_OK;
          s_d.resp = '0;
          s_d.resp[0] = p0;
          s_d.nparam = 4'h1;
          case (wb_dat_in[7:0])
            `IMUCFG_CMD_GYRO_UNIT:
            begin
              ok = p0 < 32'h10 && !p0[2];
              if (ok)
              begin
                s_d.gyro_unit = p0[3:0];
              end
            end
            `IMUCFG_CMD_SAMPLE_RATE:
            begin
              ok = p0 == 32'h7d || p0 == 32'hfa || p0 == 32'h1f4 ||
                   p0 == 32'h3e8 || p0 == 32'h7d0 || p0 == 32'h0;
              if (ok)
              begin
                s_d.rate = p0[11:0];
                s_d.ext_trig = p0 == 32'h0;
                if (p0 == 32'h0)
                begin
                  s_d.multi = 1'b0;
                end
              end
            end
            `IMUCFG_CMD_SAMPLE_EXT:
            begin
              s_d.resp[3:1] = {p3, p2, p1};
              s_d.nparam = 4'h4;
              ok = p0 == 32'h0 && p1 <= {12'h0, `IMUCFG_MAX_DELAY_US} &&
                   p2 <= {12'h0, `IMUCFG_MAX_DELAY_US} &&
                   p3 <= 32'h1;
              if (ok)
              begin
                s_d.rate = 12'h0;
                s_d.ext_trig = 1'b1;
                s_d.multi = 1'b1;
                s_d.gap = p1[19:0];
                s_d.spacing = p2[19:0];
                s_d.startup = p3[0];
              end
            end
            `IMUCFG_CMD_PPS_FILTER:
            begin
              ok = p0 <= 32'h4;
              if (ok)
              begin
                s_d.pps_filt = p0[2:0];
                case (p0[2:0])
                  3'h0: s_d.pps_hz = 9'h010;
                  3'h1: s_d.pps_hz = 9'h021;
                  3'h2: s_d.pps_hz = 9'h042;
                  3'h3: s_d.pps_hz = 9'h083;
                  default: s_d.pps_hz = 9'h106;
                endcase
              end
            end
            `IMUCFG_CMD_PPS_UNIT:
            begin
              ok = p0 <= 32'h3;
              if (ok)
              begin
                s_d.pps_unit = p0[1:0];
              end
            end
            `IMUCFG_CMD_SERIAL:
            begin
              s_d.resp[5:1] = {p5, p4, p3, p2, p1};
              s_d.nparam = 4'h6;
              ok = p0 != 32'h0 && p0[31:24] == 8'h0 &&
                   (p1 == 32'h1 || p1 == 32'h2) &&
                   (p2 == 32'h6e || p2 == 32'h6f || p2 == 32'h65) &&
                   p3 <= 32'h1 && p4 <= 32'h1 && p5 <= 32'h1;
              if (ok)
              begin
                s_d.resp[2] = p2 - 32'h20;
                s_d.pend = 1'b1;
                s_d.p_bit_rate = p0[23:0];
                s_d.p_stop2 = p1 == 32'h2;
                s_d.p_parity = p2 == 32'h6f ? 2'h1 :
                               (p2 == 32'h65 ? 2'h2 : 2'h0);
                s_d.p_term = p3[0];
                s_d.p_crlf = p4[0];
                s_d.p_idle_off = p5[0];
              end
            end
            `IMUCFG_CMD_READ_BIAS:
            begin
              ok = 1'b1;
              s_d.resp = s_q.bias;
              s_d.nparam = 4'h9;
            end
            `IMUCFG_CMD_SAVE:
            begin
              ok = 1'b1;
              s_d.nparam = 4'h0;
              s_d.save = 1'b1;
            end
            default:
            begin
              s_d.status = `IMUCFG_ST_BAD_CMD;
            end
          endcase
          if (!ok && s_d.status == `IMUCFG_ST_OK)
          begin
            s_d.status = `IMUCFG_ST_BAD_PARAM;
          end
          s_d.idx = 6'h0;
          s_d.crc = `IMUCFG_CRC_INIT;
          s_d.seq = imucfg_pkg::IMUCFG_CRC;
        end
      end
      imucfg_pkg::IMUCFG_CRC:
      begin
        s_d.crc = crc_next;
        s_d.idx = s_q.idx + 6'h01;
        if (s_q.idx == last)
        begin
          s_d.seq = imucfg_pkg::IMUCFG_IDLE;
        end
      end
      default: s_d.seq = imucfg_pkg::IMUCFG_IDLE;
    endcase

    // microsecond tick and elapsed time since last start and last end
    s_d.tick_cnt = s_q.tick_cnt + 8'h01;
    if (s_q.tick_cnt == 8'(`IMUCFG_TICK_CYC - 1))
    begin
      s_d.tick_cnt = 8'h0;
      if (s_q.since_start != `IMUCFG_MAX_DELAY_US)
      begin
        s_d.since_start = s_q.since_start + 20'h1;
      end
      // saturates one tick above the largest gap so that gap stays reachable
      if (s_q.since_end <= `IMUCFG_MAX_DELAY_US)
      begin
        s_d.since_end = s_q.since_end + 20'h1;
      end
    end
    if (frame_end_in)
    begin
      s_d.since_end = 20'h0;
    end
    // a grant is a single pulse; the requester drops its request after it
    // frame ends fall between ticks, so one extra tick keeps the full gap
    if (frame_req_in && !s_q.grant &&
        (!s_q.multi || (s_q.since_start >= s_q.spacing &&
                        (s_q.gap == 20'h0 ||
                         s_q.since_end > s_q.gap))))
    begin
      s_d.grant = 1'b1;
      s_d.since_start = 20'h0;
      s_d.tick_cnt = 8'h0;
    end
    s_d.drv_en = !s_q.idle_off || tx_active_in;
  end

  always_ff @(posedge clock_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      s_q <= '0;
      s_q.seq <= imucfg_pkg::IMUCFG_IDLE;
      s_q.gyro_unit <= `IMUCFG_RST_GYRO_UNIT;
      s_q.rate <= `IMUCFG_RST_RATE;
      s_q.pps_filt <= `IMUCFG_RST_PPS_FILT;
      s_q.pps_hz <= `IMUCFG_RST_PPS_HZ;
      s_q.pps_unit <= `IMUCFG_RST_PPS_UNIT;
      s_q.bit_rate <= `IMUCFG_RST_BIT_RATE;
      s_q.parity <= `IMUCFG_RST_PARITY;
      s_q.drv_en <= 1'b1;
      s_q.since_start <= `IMUCFG_MAX_DELAY_US;
      s_q.since_end <= `IMUCFG_MAX_DELAY_US;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign wb_dat_out = s_q.dat;
  assign wb_ack_out = s_q.ack;
  assign frame_grant_out = s_q.grant;
  assign driver_enable_out = s_q.drv_en;
  assign gyro_unit_out = s_q.gyro_unit;
  assign sample_rate_out = s_q.rate;
  assign ext_trigger_out = s_q.ext_trig;
  assign multi_module_out = s_q.multi;
  assign startup_frames_enable_out = s_q.startup;
  assign pps_filter_out = s_q.pps_filt;
  assign pps_cutoff_hz_out = s_q.pps_hz;
  assign pps_unit_out = s_q.pps_unit;
  assign bit_rate_out = s_q.bit_rate;
  assign two_stop_bits_out = s_q.stop2;
  assign parity_out = s_q.parity;
  assign receive_termination_on_out = s_q.term;
  assign frame_crlf_enable_out = s_q.crlf;
  assign driver_idle_off_out = s_q.idle_off;
  assign save_request_out = s_q.save;
endmodule // imucfg_cmd

//--- test/imucfg_cmd_properties.sv
`timescale 1ns/100ps
module imucfg_cmd_properties (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  input wire logic frame_req_in,
  input wire logic frame_grant_out,
  input wire logic tx_active_in,
  input wire logic driver_enable_out,
  input wire logic driver_idle_off_out,
  input wire logic [3:0] gyro_unit_out,
  input wire logic [11:0] sample_rate_out,
  input wire logic ext_trigger_out,
  input wire logic multi_module_out,
  input wire logic [2:0] pps_filter_out,
  input wire logic [8:0] pps_cutoff_hz_out,
  input wire logic save_request_out
);
  logic [8:0] hz_exp;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  assign hz_exp = pps_filter_out == 3'h0 ? 9'h010 :
    pps_filter_out == 3'h1 ? 9'h021 : pps_filter_out == 3'h2 ? 9'h042 :
    pps_filter_out == 3'h3 ? 9'h083 : pps_filter_out == 3'h4 ? 9'h106 : 9'h0;
  AST_ACK:
    assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=>
      wb_ack_out ##1 !wb_ack_out)
    else $error("ack not a one cycle pulse after request");
  AST_GYRO:
    assert property (gyro_unit_out[2] == 1'b0)
    else $error("gyro unit code outside accepted set");
  AST_RATE:
    assert property (sample_rate_out inside {12'h0, 12'h07d, 12'h0fa,
      12'h1f4, 12'h3e8, 12'h7d0})
    else $error("sample rate outside accepted set");
  AST_EXT:
    assert property (ext_trigger_out == (sample_rate_out == 12'h0))
    else $error("trigger flag disagrees with rate");
  AST_MULTI:
    assert property (!ext_trigger_out |-> !multi_module_out)
    else $error("multi module active without trigger");
  AST_PPS:
    assert property (pps_cutoff_hz_out == hz_exp)
    else $error("pps cutoff does not match filter code");
  AST_DRV_ON:
    assert property (tx_active_in || !driver_idle_off_out |=> driver_enable_out)
    else $error("driver off while needed");
  AST_DRV_OFF:
    assert property (!tx_active_in && driver_idle_off_out |=>
      !driver_enable_out)
    else $error("driver on while idle");
  AST_GRANT:
    assert property (frame_grant_out |-> $past(frame_req_in) ##1
      !frame_grant_out)
    else $error("grant without request or twice in a row");
  AST_SAVE:
    assert property (save_request_out |=> !save_request_out)
    else $error("save request longer than one cycle");
  COV_MULTI: cover property ($rose(multi_module_out));
  COV_SAVE: cover property (save_request_out);
  COV_DRV: cover property ($fell(driver_enable_out));
endmodule // imucfg_cmd_properties

//--- test/imucfg_link_model.sv
`timescale 1ns/100ps
// transmitter side of the frame link; LEN sets how many cycles each frame lasts
module imucfg_link_model #(
  parameter int LEN = 20
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic go_in,
  input wire logic frame_grant_in,
  output logic frame_req_out,
  output logic frame_end_out,
  output logic tx_active_out
);
  int cnt;
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      frame_req_out <= 1'b0;
      frame_end_out <= 1'b0;
      tx_active_out <= 1'b0;
      cnt <= 0;
    end
    else
    begin
      frame_end_out <= 1'b0;
      if (frame_grant_in)
      begin
        frame_req_out <= 1'b0;
        tx_active_out <= 1'b1;
        cnt <= LEN;
      end
      else if (tx_active_out)
      begin
        cnt <= cnt - 1;
        tx_active_out <= cnt != 1;
        frame_end_out <= cnt == 1;
      end
      else if (!frame_req_out)
        frame_req_out <= go_in; // a raised request waits for grant
    end
  end
endmodule // imucfg_link_model

//--- test/imucfg_cmd_tb.sv
`timescale 1ns/100ps
`include "imucfg_defines.svh"
module imucfg_cmd_tb;
  logic clock_in = 0, nrst_in = 0, wb_cyc_in = 0, wb_stb_in = 0;
  logic wb_we_in = 0, go = 0;
  logic [7:0] wb_adr_in = 0;
  logic [31:0] wb_dat_in = 0, wb_dat_out, q;
  logic wb_ack_out, frame_req_in, frame_end_in, tx_active_in;
  logic frame_grant_out, multi_module_out, startup_frames_enable_out;
  logic two_stop_bits_out, receive_termination_on_out, frame_crlf_enable_out;
  logic driver_idle_off_out, save_request_out;
  logic [3:0] gyro_unit_out, ge;
  logic [11:0] sample_rate_out, re;
  logic [8:0] pps_cutoff_hz_out;
  logic [1:0] pps_unit_out, parity_out;
  logic [23:0] bit_rate_out;
  logic [31:0] par [6] = '{default: 0};
  logic [11:0] rates [7] = '{12'h07d, 12'h0fa, 12'h1f4, 12'h3e8, 12'h7d0,
    12'h0, 12'h3e7};
  logic [8:0] hzt [5] = '{9'h010, 9'h021, 9'h042, 9'h083, 9'h106};
  logic [7:0] lt [4] = '{8'h6e, 8'h6f, 8'h65, 8'h78};
  int n_errors = 0, n_checks = 0, n_save = 0, n_grant = 0;
  int cyc_n = 0, t_last = 0, delta = 0, k, s0;
  imucfg_cmd u_dut (.clock_in, .nrst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
    .wb_adr_in, .wb_sel_in(4'hf), .wb_dat_in, .wb_dat_out, .wb_ack_out,
    .frame_req_in, .frame_end_in, .tx_active_in, .frame_grant_out,
    .driver_enable_out(), .gyro_unit_out, .sample_rate_out,
    .ext_trigger_out(), .multi_module_out, .startup_frames_enable_out,
    .pps_filter_out(), .pps_cutoff_hz_out, .pps_unit_out, .bit_rate_out,
    .two_stop_bits_out, .parity_out, .receive_termination_on_out,
    .frame_crlf_enable_out, .driver_idle_off_out, .save_request_out);
  imucfg_link_model u_link (.clock_in, .nrst_in, .go_in(go),
    .frame_grant_in(frame_grant_out), .frame_req_out(frame_req_in),
    .frame_end_out(frame_end_in), .tx_active_out(tx_active_in));
  initial forever #2.5 clock_in = ~clock_in;
  always @(posedge clock_in)
  begin
    cyc_n <= cyc_n + 1;
    if (save_request_out === 1'b1)
      n_save <= n_save + 1;
    if (frame_grant_out === 1'b1)
    begin
      n_grant <= n_grant + 1;
      delta <= cyc_n - t_last;
      t_last <= cyc_n;
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(input string nm);
    n_errors++;
    $display("ERROR %s expected done seen timeout", nm);
    conclude();
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_in);
    wb_cyc_in <= 1;
    wb_stb_in <= 1;
    wb_we_in <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    n = 0;
    do
    begin
      @(posedge clock_in);
      n++;
    end
    while (wb_ack_out !== 1'b1 && n < 20);
    q = wb_dat_out;
    wb_cyc_in <= 0;
    wb_stb_in <= 0;
    wb_we_in <= 0;
    if (n >= 20)
      hang("bus ack");
  endtask
  // q holds busy; status is checked with the command code beside it
  task automatic run(input logic [7:0] c, input logic [7:0] est);
    int i;
    for (i = 0; i < 6; i++)
      wb(1, 8'h04 + 8'(4 * i), par[i]);
    wb(1, `IMUCFG_OFS_CMD, {24'h0, c});
    i = 0;
    do
    begin
      wb(0, `IMUCFG_OFS_CMD, 0);
      i++;
    end
    while (q[0] !== 1'b0 && i < 60);
    if (i >= 60)
      hang("busy");
    wb(0, `IMUCFG_OFS_STATUS, 0);
    chk("status", {16'h0, c, est}, {16'h0, q[15:0]});
  endtask
  task automatic frames(input int lo, input int hi);
    int i, g0;
    g0 = n_grant;
    go <= 1;
    for (i = 0; i < 4000 && n_grant < g0 + 2; i++)
      @(posedge clock_in);
    go <= 0;
    if (i >= 4000)
      hang("grant");
    chk("grant spacing", 1, 32'(delta >= lo && delta <= hi));
    for (i = 0; i < 2000 && (frame_req_in | tx_active_in) !== 1'b0; i++)
      @(posedge clock_in);
    if (i >= 2000)
      hang("link idle");
  endtask
  function automatic logic [7:0] crc8(input logic [47:0] v);
    logic [7:0] c;
    c = 8'h0;
    for (int i = 47; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  initial
  begin
    repeat (3) @(posedge clock_in);
    nrst_in <= 1;
    repeat (3) @(posedge clock_in);
    wb(0, `IMUCFG_OFS_CONF, 0);
    chk("conf reset", 32'h00106200, q);
    wb(0, `IMUCFG_OFS_DEC, 0);
    chk("decimals", 32'h765, q);
    wb(1, 8'hfc, 32'hffffffff);
    wb(0, 8'hfc, 0);
    chk("unmapped", 0, q);
    ge = 0;
    for (k = 0; k < 16; k++)
    begin
      par[0] = 32'(k);
      if (k < 4 || (k > 7 && k < 12))
        ge = 4'(k);
      run(`IMUCFG_CMD_GYRO_UNIT, 8'(ge != 4'(k)));
      chk("gyro", {28'h0, ge}, {28'h0, gyro_unit_out});
    end
    run(8'h3f, `IMUCFG_ST_BAD_CMD);
    par[0] = 2;
    run(`IMUCFG_CMD_GYRO_UNIT, 8'h0);
    wb(0, `IMUCFG_OFS_CRC, 0);
    chk("crc", {16'h0d, crc8(48'h010000000002)}, q);
    for (k = 0; k < 6; k++)
    begin
      par[0] = 32'(k);
      run(`IMUCFG_CMD_PPS_FILTER, 8'(k > 4));
      chk("pps hz", {23'h0, hzt[k > 4 ? 4 : k]}, {23'h0, pps_cutoff_hz_out});
      run(`IMUCFG_CMD_PPS_UNIT, 8'(k > 3));
      chk("pps unit", 32'(k > 3 ? 3 : k), {30'h0, pps_unit_out});
    end
    for (k = 0; k < 4; k++)
    begin
      par = '{32'h1c200, 2, {24'h0, lt[k]}, 1, 1, 1};
      run(`IMUCFG_CMD_SERIAL, 8'(k == 3));
      if (k == 0)
        chk("early rate", 32'h0e1000, {8'h0, bit_rate_out});
      wb(0, 8'h48, 0);
      if (k < 3)
        chk("parity echo", {24'h0, lt[k] - 8'h20}, q);
      wb(0, `IMUCFG_OFS_CRC, 0);
      if (k < 3)
        chk("parity", 32'(k), {30'h0, parity_out});
    end
    chk("serial", {28'h1c200, 4'hf}, {4'h0, bit_rate_out, two_stop_bits_out,
      receive_termination_on_out, frame_crlf_enable_out,
      driver_idle_off_out});
    re = 12'h7d0;
    for (k = 0; k < 7; k++)
    begin
      par[0] = {20'h0, rates[k]};
      if (k < 6)
        re = rates[k];
      run(`IMUCFG_CMD_SAMPLE_RATE, 8'(k == 6));
      chk("rate", {20'h0, re}, {20'h0, sample_rate_out});
    end
    par = '{0, 1, 3, 1, 0, 0};
    run(`IMUCFG_CMD_SAMPLE_EXT, 8'h0);
    chk("multi", 1, {31'h0, multi_module_out});
    chk("startup", 1, {31'h0, startup_frames_enable_out});
    frames(600, 810);
    par = '{0, 1000001, 0, 0, 0, 0};
    run(`IMUCFG_CMD_SAMPLE_EXT, 8'h1);
    par = '{0, 2, 0, 0, 0, 0};
    run(`IMUCFG_CMD_SAMPLE_EXT, 8'h0);
    chk("startup", 0, {31'h0, startup_frames_enable_out});
    frames(420, 700);
    par[1] = 0;
    run(`IMUCFG_CMD_SAMPLE_RATE, 8'h0);
    chk("multi", 0, {31'h0, multi_module_out});
    frames(21, 40);
    for (k = 0; k < 9; k++)
      wb(1, 8'h80 + 8'(4 * k), 32'(k * 7 - 20));
    run(`IMUCFG_CMD_READ_BIAS, 8'h0);
    for (k = 0; k < 9; k++)
    begin
      wb(0, 8'h40 + 8'(4 * k), 0);
      chk("bias", 32'(k * 7 - 20), q);
    end
    s0 = n_save;
    run(`IMUCFG_CMD_SAVE, 8'h0);
    chk("save", 32'(s0 + 1), 32'(n_save));
    // settings must not survive a reset without storage
    nrst_in <= 0;
    repeat (3) @(posedge clock_in);
    nrst_in <= 1;
    repeat (3) @(posedge clock_in);
    wb(0, `IMUCFG_OFS_CONF, 0);
    chk("conf after reset", 32'h00106200, q);
    chk("rate after reset", 32'h0e1000, {8'h0, bit_rate_out});
    conclude();
  end
endmodule // imucfg_cmd_tb
bind imucfg_cmd imucfg_cmd_properties u_props (.clock_in, .nrst_in,
  .wb_cyc_in, .wb_stb_in, .wb_ack_out, .frame_req_in, .frame_grant_out,
  .tx_active_in, .driver_enable_out, .driver_idle_off_out, .gyro_unit_out,
  .sample_rate_out, .ext_trigger_out, .multi_module_out, .pps_filter_out,
  .pps_cutoff_hz_out, .save_request_out);
